// ===== dv/dpm_control_props.sv
`timescale 1ns/1ns
// Watches pointer, sequencer and mute behaviour at the control block's ports.
module dpm_control_props #(
   parameter int POWERUP_CYC = dpm_pkg::DPM_POWERUP_CYC // Power-up length in system clocks.
) (
   input wire logic clk_sys, // System clock.
   input wire logic rst, // Synchronous reset.
   input wire logic reset_pin_n, // Device reset pin.
   input wire logic ratio_valid, // Clock ratio valid.
   input wire dpm_pkg::dpm_soft_cfg_t soft_cfg, // Register settings.
   input wire logic ptr_load, // Pointer load strobe.
   input wire logic [7:0] ptr_value, // Pointer byte.
   input wire logic byte_done, // Data byte strobe.
   input wire logic [7:0] ptr, // Register pointer.
   input wire dpm_pkg::dpm_eff_cfg_t eff_cfg, // Effective configuration.
   input wire logic [7:0] osr, // Oversampling ratio.
   input wire logic powered_down, // Low power flag.
   input wire logic powering_up, // Power-up flag.
   input wire logic mute_control // Mute output.
);
   logic [2:0] pin_hist;
   logic [15:0] pu_cnt;
   default clocking cb @(posedge clk_sys); endclocking
   // Both rst and the pin clear the synchroniser, so the pointer is trusted three edges later.
   always_ff @(posedge clk_sys) begin
      pin_hist <= rst ? 3'h0 : {pin_hist[1:0], reset_pin_n};
      pu_cnt <= powering_up ? pu_cnt + 16'h0001 : 16'h0000;
   end
   wire pin_ok = &pin_hist;
   AST_PTR_RST: assert property (rst |=> ptr == 8'h00)
      else $error("pointer not cleared");
   AST_PTR_LOAD: assert property (disable iff (rst) pin_ok && ptr_load
      |=> ptr == $past(ptr_value)) else $error("pointer load lost");
   AST_PTR_HOLD: assert property (disable iff (rst)
      pin_ok && !ptr_load && byte_done && !ptr[7] |=> $stable(ptr))
      else $error("pointer moved without flag");
   AST_PTR_INC: assert property (disable iff (rst)
      pin_ok && !ptr_load && byte_done && ptr[7]
      |=> ptr[7:5] == $past(ptr[7:5]) && ptr[4:0] == $past(ptr[4:0]) + 5'h01)
      else $error("pointer increment wrong");
   AST_MUTE_RST: assert property (rst |=> mute_control)
      else $error("mute off in reset");
   AST_MUTE_RATIO: assert property (disable iff (rst) !ratio_valid |-> mute_control)
      else $error("mute off on bad ratio");
   AST_MUTE_PWR: assert property (disable iff (rst)
      powered_down || powering_up |-> mute_control) else $error("mute off while powering");
   AST_HW_FAST: assert property (disable iff (rst)
      !eff_cfg.soft_mode |-> !eff_cfg.slow_rolloff) else $error("slow filter in pin mode");
   AST_HW_DEEMPH: assert property (disable iff (rst) !eff_cfg.soft_mode
      |-> eff_cfg.deemph inside {dpm_pkg::DPM_DEEMPH_OFF, dpm_pkg::DPM_DEEMPH_44K})
      else $error("bad pin de-emphasis");
   AST_SW_ROLL: assert property (disable iff (rst)
      eff_cfg.soft_mode && $past(eff_cfg.soft_mode)
      |-> eff_cfg.slow_rolloff == $past(soft_cfg.rolloff_select))
      else $error("roll-off select ignored");
   AST_PU_LEN: assert property (disable iff (rst) $fell(powering_up) && !powered_down
      |-> pu_cnt >= POWERUP_CYC - 1 && pu_cnt <= POWERUP_CYC + 1)
      else $error("power-up length wrong");
   AST_OSR: assert property (disable iff (rst)
      osr == (eff_cfg.speed == dpm_pkg::DPM_SPEED_QUAD ? dpm_pkg::DPM_OSR_QUAD :
      eff_cfg.speed == dpm_pkg::DPM_SPEED_DOUBLE ? dpm_pkg::DPM_OSR_DOUBLE :
      dpm_pkg::DPM_OSR_SINGLE)) else $error("wrong ratio");
endmodule // dpm_control_props
bind dpm_control dpm_control_props #(.POWERUP_CYC(POWERUP_CYC)) props_u (.clk_sys(clk_sys),
   .rst(rst), .reset_pin_n(reset_pin_n), .ratio_valid(ratio_valid), .soft_cfg(soft_cfg),
   .ptr_load(ptr_load), .ptr_value(ptr_value), .byte_done(byte_done), .ptr(ptr),
   .eff_cfg(eff_cfg), .osr(osr), .powered_down(powered_down), .powering_up(powering_up),
   .mute_control(mute_control));

// ===== dv/dpm_host_model.sv
`timescale 1ns/1ns
// Host on the control port, plus the audio source that makes the frame clock.
module dpm_host_model (
   input wire logic clk_sys, // System clock.
   output logic frame_clock, // Frame clock, also the stream enable pin.
   output dpm_pkg::dpm_soft_cfg_t soft_cfg, // Register settings.
   output logic port_enable_write, // Port enable write strobe.
   output logic ptr_load, // Pointer byte strobe.
   output logic [7:0] ptr_value, // Pointer byte.
   output logic byte_done // Data byte strobe.
);
   logic run;
   logic lvl;
   // Settings start powered down so they can be loaded before power-up.
   initial begin
      soft_cfg = '0;
      soft_cfg.power_down_bit = 1'b1;
      {port_enable_write, ptr_load, byte_done, run, lvl} = '0;
      ptr_value = 8'h5a;
      frame_clock = 1'b0;
      #3;
      forever begin
         #40 frame_clock = run ? ~frame_clock : lvl;
      end
   end
   // Strobes rise after a falling edge and last one cycle, so each counts once.
   task automatic frame(input logic r, input logic l);
      run = r;
      lvl = l;
   endtask
   task automatic set_cfg(input dpm_pkg::dpm_soft_cfg_t c);
      @(negedge clk_sys);
      soft_cfg = c;
   endtask
   task automatic strobe_ptr(input logic [7:0] v);
      @(negedge clk_sys);
      ptr_load = 1'b1;
      ptr_value = v;
      @(negedge clk_sys);
      ptr_load = 1'b0;
      ptr_value = ~v; // A released byte never shows the old pointer.
   endtask
   task automatic strobe_byte();
      @(negedge clk_sys);
      byte_done = 1'b1;
      @(negedge clk_sys);
      byte_done = 1'b0;
   endtask
   task automatic write_enable();
      @(negedge clk_sys);
      soft_cfg.port_enable_bit = 1'b1;
      port_enable_write = 1'b1;
      @(negedge clk_sys);
      port_enable_write = 1'b0;
   endtask
endmodule // dpm_host_model

// ===== dv/tb.sv
`timescale 1ns/1ns
module tb;
   logic clk_sys, rst, reset_pin_n, ratio_valid, powered_down, powering_up, mute_control;
   logic [3:0] mode_pins;
   logic [15:0] sample_rate_q0, deemph_scale_q8;
   logic [7:0] ptr, osr;
   wire logic frame_clock, port_enable_write, ptr_load, byte_done;
   wire logic [7:0] ptr_value;
   wire dpm_pkg::dpm_soft_cfg_t soft_cfg;
   dpm_pkg::dpm_eff_cfg_t eff_cfg;
   dpm_pkg::dpm_soft_cfg_t cfg;
   int error_cnt = 0;
   int checks = 0;
   dpm_pkg::dpm_speed_t sp[3] = '{dpm_pkg::DPM_SPEED_SINGLE, dpm_pkg::DPM_SPEED_DOUBLE,
      dpm_pkg::DPM_SPEED_QUAD};
   logic [7:0] os[3] = '{dpm_pkg::DPM_OSR_SINGLE, dpm_pkg::DPM_OSR_DOUBLE, dpm_pkg::DPM_OSR_QUAD};
   // Short power-up and stream hold keep the run brief; a frame half period is 4 clocks.
   dpm_control #(.POWERUP_CYC(20), .STREAM_HOLD_CYC(100)) dut_u (.clk_sys(clk_sys),
      .rst(rst),
      .reset_pin_n(reset_pin_n), .frame_clock(frame_clock), .mode_pins(mode_pins),
      .ratio_valid(ratio_valid), .soft_cfg(soft_cfg), .port_enable_write(port_enable_write),
      .ptr_load(ptr_load), .ptr_value(ptr_value), .byte_done(byte_done), .ptr(ptr),
      .eff_cfg(eff_cfg), .osr(osr), .deemph_scale_q8(deemph_scale_q8),
      .sample_rate_q0(sample_rate_q0), .powered_down(powered_down),
      .powering_up(powering_up), .mute_control(mute_control));
   dpm_host_model host_u (.clk_sys(clk_sys), .frame_clock(frame_clock), .soft_cfg(soft_cfg),
      .port_enable_write(port_enable_write), .ptr_load(ptr_load), .ptr_value(ptr_value),
      .byte_done(byte_done));
   // Free-running 100 MHz system clock.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Every result is widened to 16 bits so one compare serves all.
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apply();
      host_u.set_cfg(cfg);
      repeat (3) @(negedge clk_sys);
   endtask
   // Bounded wait on the sequencer flags; running out shows as a mismatch.
   task automatic wait_state(input logic [1:0] st, input int limit);
      int n;
      n = 0;
      while ({powered_down, powering_up} !== st && n < limit) begin
         @(negedge clk_sys);
         n++;
      end
      chk("state", {14'h0, st}, {14'h0, powered_down, powering_up});
   endtask
   task automatic summarize();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // The run needs about 13000 cycles; this limit is three times that.
   initial begin
      #400000;
      chk("watchdog", 16'h0000, 16'h0001);
      summarize();
   end
   initial begin
      {rst, reset_pin_n, ratio_valid, mode_pins, sample_rate_q0} = {3'h7, 4'h4, 16'h113a};
      cfg = '0;
      cfg.power_down_bit = 1'b1;
      cfg.rolloff_select = 1'b1;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      chk("ptr", 16'h0000, {8'h00, ptr});
      chk("mute", 16'h0001, {15'h0, mute_control});
      host_u.frame(1'b1, 1'b0);
      host_u.set_cfg(cfg);
      host_u.strobe_ptr(8'h9f);
      chk("ptr", 16'h009f, {8'h00, ptr});
      host_u.strobe_byte();
      chk("ptr", 16'h0080, {8'h00, ptr});
      host_u.strobe_ptr(8'h05);
      host_u.strobe_byte();
      chk("ptr", 16'h0005, {8'h00, ptr});
      $display("test pointer done");
      repeat (3800) @(negedge clk_sys);
      chk("pd", 16'h0001, {15'h0, powered_down});
      wait_state(2'b01, 1000);
      wait_state(2'b00, 40);
      chk("soft", 16'h0000, {15'h0, eff_cfg.soft_mode});
      chk("slow", 16'h0000, {15'h0, eff_cfg.slow_rolloff});
      chk("deemph", {14'h0, dpm_pkg::DPM_DEEMPH_44K}, {14'h0, eff_cfg.deemph});
      chk("osr", {8'h00, dpm_pkg::DPM_OSR_SINGLE}, {8'h00, osr});
      chk("mute", 16'h0000, {15'h0, mute_control});
      ratio_valid = 1'b0;
      @(negedge clk_sys);
      chk("mute", 16'h0001, {15'h0, mute_control});
      ratio_valid = 1'b1;
      // The stream pin must outlast the hold time before the block takes it.
      host_u.frame(1'b0, 1'b1);
      mode_pins = 4'h5;
      repeat (120) @(negedge clk_sys);
      chk("stream", 16'h0001, {15'h0, eff_cfg.one_bit_stream});
      chk("rate", 16'h0005, {13'h0, eff_cfg.stream_rate});
      chk("format", 16'h0001, {13'h0, eff_cfg.format});
      host_u.frame(1'b0, 1'b0);
      mode_pins = 4'hc;
      repeat (10) @(negedge clk_sys);
      chk("osr", {8'h00, dpm_pkg::DPM_OSR_QUAD}, {8'h00, osr});
      $display("test pin mode done");
      host_u.write_enable();
      cfg.port_enable_bit = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk("soft", 16'h0001, {15'h0, eff_cfg.soft_mode});
      chk("slow", 16'h0001, {15'h0, eff_cfg.slow_rolloff});
      wait_state(2'b10, 10);
      for (int i = 0; i < 4; i++) begin
         cfg.deemph_bits = 2'(i);
         apply();
         chk("deemph", 16'(i), {14'h0, eff_cfg.deemph});
      end
      for (int i = 0; i < 3; i++) begin
         cfg.speed_mode_field = sp[i];
         apply();
         chk("osr", {8'h00, os[i]}, {8'h00, osr});
      end
      {cfg.speed_mode_field, cfg.format_field, cfg.mix_enable} = {dpm_pkg::DPM_SPEED_STREAM, 7'h6a};
      apply();
      chk("stream", 16'h0001, {15'h0, eff_cfg.one_bit_stream});
      chk("rate", 16'h0006, {13'h0, eff_cfg.stream_rate});
      chk("format", 16'h0006, {13'h0, eff_cfg.format});
      chk("mix", 16'h000a, {12'h0, eff_cfg.mix_enable});
      {cfg.speed_mode_field, cfg.power_down_bit} = {dpm_pkg::DPM_SPEED_SINGLE, 1'b0};
      host_u.set_cfg(cfg);
      wait_state(2'b01, 10);
      wait_state(2'b00, 40);
      cfg.mute_bits = 1'b1;
      apply();
      chk("mute", 16'h0001, {15'h0, mute_control});
      chk("scale", 16'h0100, deemph_scale_q8);
      sample_rate_q0 = 16'h12c0;
      repeat (3) @(negedge clk_sys);
      chk("scale", 16'h0116, deemph_scale_q8);
      $display("test soft mode done");
      // The clocks and straps change only while the pin reset is held.
      host_u.strobe_ptr(8'h83);
      reset_pin_n = 1'b0;
      host_u.frame(1'b1, 1'b0);
      mode_pins = 4'h8;
      repeat (5) @(negedge clk_sys);
      chk("ptr", 16'h0000, {8'h00, ptr});
      chk("pd", 16'h0001, {15'h0, powered_down});
      chk("soft", 16'h0000, {15'h0, eff_cfg.soft_mode});
      chk("mute", 16'h0001, {15'h0, mute_control});
      reset_pin_n = 1'b1;
      // Double speed waits 1024 frames of 8 clocks each before the pin start.
      repeat (7900) @(negedge clk_sys);
      chk("pd", 16'h0001, {15'h0, powered_down});
      chk("mute", 16'h0001, {15'h0, mute_control});
      wait_state(2'b01, 600);
      wait_state(2'b00, 40);
      chk("soft", 16'h0000, {15'h0, eff_cfg.soft_mode});
      chk("osr", {8'h00, dpm_pkg::DPM_OSR_DOUBLE}, {8'h00, osr});
      chk("mute", 16'h0000, {15'h0, mute_control});
      $display("test pin reset done");
      summarize();
   end
endmodule // tb

// ===== include/dpm_pkg.sv
package dpm_pkg;
   // Speed modes, shared by the mode pins and the speed mode field.
   typedef enum logic [1:0] {
      DPM_SPEED_SINGLE = 2'h0,
      DPM_SPEED_DOUBLE = 2'h1,
      DPM_SPEED_QUAD = 2'h2,
      DPM_SPEED_STREAM = 2'h3
   } dpm_speed_t;

   // De-emphasis selections.
   typedef enum logic [1:0] {
      DPM_DEEMPH_OFF = 2'h0,
      DPM_DEEMPH_32K = 2'h1,
      DPM_DEEMPH_44K = 2'h2,
      DPM_DEEMPH_48K = 2'h3
   } dpm_deemph_t;

   // Software configuration as loaded through the control port.
   typedef struct packed {
      logic port_enable_bit;
      logic power_down_bit;
      logic rolloff_select;
      logic [1:0] deemph_bits;
      dpm_speed_t speed_mode_field;
      logic [2:0] format_field;
      logic ramp_up_bit;
      logic ramp_down_bit;
      logic mute_bits;
      logic [3:0] mix_enable;
   } dpm_soft_cfg_t;

   // Effective configuration handed to the datapath.
   typedef struct packed {
      logic soft_mode;
      logic slow_rolloff;
      dpm_deemph_t deemph;
      dpm_speed_t speed;
      logic one_bit_stream;
      logic [2:0] stream_rate;
      logic [2:0] format;
      logic [3:0] mix_enable;
   } dpm_eff_cfg_t;

   // Pointer layout: flag in bit 7, address in bits 4 to 0.
   localparam int DPM_PTR_FLAG_BIT = 7;
   localparam int DPM_PTR_ADDR_W = 5;
   localparam logic [7:0] DPM_PTR_RESET = 8'h00;

   // Post-reset wait, in frame clock cycles, per speed mode.
   localparam logic [11:0] DPM_WAIT_SINGLE = 12'h200;
   localparam logic [11:0] DPM_WAIT_DOUBLE = 12'h400;
   localparam logic [11:0] DPM_WAIT_QUAD = 12'h800;

   // Power-up ramp time and its cycle count at the system clock.
   localparam int DPM_CLK_MHZ = 100;
   localparam int DPM_POWERUP_US = 50;
   localparam int DPM_POWERUP_CYC = DPM_POWERUP_US * DPM_CLK_MHZ;

   // The stream pin must stay high longer than half a frame at the slowest 4 kHz rate,
   // so a running frame clock is never taken for a held stream enable.
   localparam int DPM_STREAM_HOLD_CYC = 12500;

   // Oversampling ratios per speed mode.
   localparam logic [7:0] DPM_OSR_SINGLE = 8'h80;
   localparam logic [7:0] DPM_OSR_DOUBLE = 8'h40;
   localparam logic [7:0] DPM_OSR_QUAD = 8'h20;

   // Control state machine, Gray coded along reset, wait, powerup, run.
   typedef enum logic [1:0] {
      DPM_ST_LOWPWR = 2'h0,
      DPM_ST_WAIT = 2'h1,
      DPM_ST_POWERUP = 2'h3,
      DPM_ST_RUN = 2'h2
   } dpm_state_t;
endpackage

// ===== rtl/dpm_control.sv
`timescale 1ns/1ns
// Behaviour
// - Software mode: roll-off select bit picks fast or slow filter, every speed.
// - Hardware mode always uses the fast roll-off filter.
// - Software mode: de-emphasis bits pick 32, 44.1 or 48 kHz coefficients.
// - Hardware mode: only 44.1 kHz de-emphasis, enabled by mode pin two high with mode pin three low.
// - Mismatched rate scales de-emphasis corners by actual rate over 44100.
// - Channel mixing applies independently to each A-B channel pair.
// - Pin mode: stream-enable pin high selects bit stream; pins give rate.
// - Software mode: speed field selects bit stream; format field gives rate.
// - Mute outputs active in power-up, reset, mute and bad clock ratio.
// - Reset low returns registers to default and keeps device powered down.
// - After reset, wait 512, 1024 or 2048 frame clocks, then power up.
// - No port enable write before count expiry: hardware mode from pins.
// - Port enable write accepted any time, switching to software control.
// - Clearing the power-down bit starts a power-up lasting about 50 us.
// - Control port runs independently of the audio sample rate.
// - Auto-increment flag clear: pointer holds across successive bytes.
// - Auto-increment flag set: pointer advances after each data byte.
// - Pointer is eight bits, five address bits, resets to zero.
// - Speeds: single 128x to 50 kHz, double 64x, quad 32x.
module dpm_control #(
   parameter int POWERUP_CYC = dpm_pkg::DPM_POWERUP_CYC, // Power-up length.
   parameter int STREAM_HOLD_CYC = dpm_pkg::DPM_STREAM_HOLD_CYC // Stream pin hold time.
) (
   input wire logic clk_sys, // System clock, 100 MHz.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic reset_pin_n, // Device reset pin, active low, asynchronous.
   input wire logic frame_clock, // Frame clock pin, also the stream enable.
   input wire logic [3:0] mode_pins, // Strap pins, asynchronous.
   input wire logic ratio_valid, // Clock ratio detector says ratio is valid.
   input wire dpm_pkg::dpm_soft_cfg_t soft_cfg, // Loaded register settings.
   input wire logic port_enable_write, // Pulse: port enable bit was written.
   input wire logic ptr_load, // Pulse: pointer byte received.
   input wire logic [7:0] ptr_value, // Received pointer byte.
   input wire logic byte_done, // Pulse: data byte transferred.
   output logic [7:0] ptr, // Register pointer.
   output dpm_pkg::dpm_eff_cfg_t eff_cfg, // Effective configuration.
   output logic [7:0] osr, // Oversampling ratio of current speed.
   output logic [15:0] deemph_scale_q8, // Corner scale, actual over 44100.
   input wire logic [15:0] sample_rate_q0, // Measured sample rate in 10 Hz units.
   output logic powered_down, // Device held in low power.
   output logic powering_up, // Power-up ramp in progress.
   output logic mute_control // Mute control output, active high.
);
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] fclk_sync;
      logic fclk_prev;
      logic [13:0] hi_cnt;
      logic [3:0] pin_sync1;
      logic [3:0] pin_sync2;
      dpm_pkg::dpm_state_t st;
      logic [11:0] wait_cnt;
      logic [12:0] pup_cnt;
      logic soft_mode;
      logic hw_started;
      dpm_pkg::dpm_eff_cfg_t cfg;
      logic [15:0] scale;
   } dpm_ctl_state_t;

   dpm_ctl_state_t state;
   dpm_ctl_state_t next_state;
   logic frame_rise;
   logic dev_reset;
   logic [3:0] pins;
   logic stream_pin;
   logic want_power;
   dpm_pkg::dpm_speed_t cur_speed;

   // Terminal count of the post-reset wait for a given speed.
   function automatic logic [11:0] wait_limit(input dpm_pkg::dpm_speed_t s);
      case (s)
         dpm_pkg::DPM_SPEED_DOUBLE: wait_limit = dpm_pkg::DPM_WAIT_DOUBLE;
         dpm_pkg::DPM_SPEED_QUAD: wait_limit = dpm_pkg::DPM_WAIT_QUAD;
         default: wait_limit = dpm_pkg::DPM_WAIT_SINGLE;
      endcase
   endfunction

   // Oversampling ratio of a speed mode.
   function automatic logic [7:0] speed_osr(input dpm_pkg::dpm_speed_t s);
      case (s)
         dpm_pkg::DPM_SPEED_DOUBLE: speed_osr = dpm_pkg::DPM_OSR_DOUBLE;
         dpm_pkg::DPM_SPEED_QUAD: speed_osr = dpm_pkg::DPM_OSR_QUAD;
         default: speed_osr = dpm_pkg::DPM_OSR_SINGLE;
      endcase
   endfunction

   // Speed implied by the strap pins, mode pins three and two.
   function automatic dpm_pkg::dpm_speed_t pin_speed(input logic [3:0] p);
      case (p[3:2])
         2'h2: pin_speed = dpm_pkg::DPM_SPEED_DOUBLE;
         2'h3: pin_speed = dpm_pkg::DPM_SPEED_QUAD;
         default: pin_speed = dpm_pkg::DPM_SPEED_SINGLE;
      endcase
   endfunction

   // Synchronised views; only second-stage flops feed logic.
   assign dev_reset = ~state.rst_sync[1];
   assign pins = state.pin_sync2;
   assign stream_pin = (state.hi_cnt == 14'(STREAM_HOLD_CYC));
   assign frame_rise = state.fclk_sync[1] & ~state.fclk_prev;

   // Speed seen by the wait counter is whichever source rules right now.
   assign cur_speed = state.soft_mode ? soft_cfg.speed_mode_field : pin_speed(pins);

   // Software mode powers up when the power-down bit is clear.
   assign want_power = state.soft_mode ? ~soft_cfg.power_down_bit : state.hw_started;

   always_comb begin
      next_state = state;
      next_state.rst_sync = {state.rst_sync[0], reset_pin_n};
      next_state.fclk_sync = {state.fclk_sync[0], frame_clock};
      next_state.fclk_prev = state.fclk_sync[1];

      // Only a level held past any frame half period counts as a stream enable.
      if (!state.fclk_sync[1]) begin
         next_state.hi_cnt = 14'h0000;
      end else if (state.hi_cnt != 14'(STREAM_HOLD_CYC)) begin
         next_state.hi_cnt = state.hi_cnt + 14'h0001;
      end
      next_state.pin_sync1 = mode_pins;
      next_state.pin_sync2 = state.pin_sync1;

      // Port enable may arrive in any state, even after a pin start.
      if (port_enable_write && soft_cfg.port_enable_bit) begin
         next_state.soft_mode = 1'b1;
      end

      case (state.st)
         dpm_pkg::DPM_ST_LOWPWR: begin
            next_state.wait_cnt = 12'h000;
            next_state.st = dpm_pkg::DPM_ST_WAIT;
         end
         dpm_pkg::DPM_ST_WAIT: begin
            // Counter freezes once software has taken over.
            if (!state.soft_mode && frame_rise) begin
               if (state.wait_cnt + 12'h001 >= wait_limit(cur_speed)) begin
                  next_state.hw_started = 1'b1;
               end else begin
                  next_state.wait_cnt = state.wait_cnt + 12'h001;
               end
            end
            if (want_power) begin
               next_state.pup_cnt = 13'h0000;
               next_state.st = dpm_pkg::DPM_ST_POWERUP;
            end
         end
         dpm_pkg::DPM_ST_POWERUP: begin
            if (!want_power) begin
               next_state.st = dpm_pkg::DPM_ST_WAIT;
            end else if (state.pup_cnt >= 13'(POWERUP_CYC - 1)) begin
               next_state.st = dpm_pkg::DPM_ST_RUN;
            end else begin
               next_state.pup_cnt = state.pup_cnt + 13'h0001;
            end
         end
         dpm_pkg::DPM_ST_RUN: begin
            if (!want_power) begin
               next_state.st = dpm_pkg::DPM_ST_WAIT;
            end
         end
         default: next_state.st = dpm_pkg::DPM_ST_LOWPWR;
      endcase

      // Effective configuration from the ruling source.
      if (state.soft_mode) begin
         next_state.cfg.soft_mode = 1'b1;
         next_state.cfg.slow_rolloff = soft_cfg.rolloff_select;
         next_state.cfg.deemph = dpm_pkg::dpm_deemph_t'(soft_cfg.deemph_bits);
         next_state.cfg.one_bit_stream =
            (soft_cfg.speed_mode_field == dpm_pkg::DPM_SPEED_STREAM);
         next_state.cfg.speed = soft_cfg.speed_mode_field;
         next_state.cfg.stream_rate = soft_cfg.format_field;
         next_state.cfg.format = soft_cfg.format_field;
         next_state.cfg.mix_enable = soft_cfg.mix_enable;
      end else begin
         next_state.cfg.soft_mode = 1'b0;
         next_state.cfg.slow_rolloff = 1'b0;
         next_state.cfg.deemph = (pins[3:2] == 2'h1) ?
            dpm_pkg::DPM_DEEMPH_44K : dpm_pkg::DPM_DEEMPH_OFF;
         next_state.cfg.one_bit_stream = stream_pin;
         next_state.cfg.speed = stream_pin ? dpm_pkg::DPM_SPEED_STREAM : pin_speed(pins);
         next_state.cfg.stream_rate = pins[2:0];
         next_state.cfg.format = {1'b0, pins[1:0]};
         next_state.cfg.mix_enable = 4'hf;
      end

      // Corner scale in 8.8 fixed point: rate in 10 Hz units over 4410.
      next_state.scale = 16'(({16'h0000, sample_rate_q0} << 8) / 32'd4410);

      // Reset pin low forces defaults and low power.
      if (dev_reset) begin
         next_state.st = dpm_pkg::DPM_ST_LOWPWR;
         next_state.soft_mode = 1'b0;
         next_state.hw_started = 1'b0;
         next_state.wait_cnt = 12'h000;
         next_state.pup_cnt = 13'h0000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state.rst_sync <= 2'h0;
         state.fclk_sync <= 2'h0;
         state.fclk_prev <= 1'b0;
         state.hi_cnt <= 14'h0000;
         state.pin_sync1 <= 4'h0;
         state.pin_sync2 <= 4'h0;
         state.st <= dpm_pkg::DPM_ST_LOWPWR;
         state.wait_cnt <= 12'h000;
         state.pup_cnt <= 13'h0000;
         state.soft_mode <= 1'b0;
         state.hw_started <= 1'b0;
         state.cfg <= '0;
         state.scale <= 16'h0000;
      end else begin
         state <= next_state;
      end
   end

   // The pointer runs on the system clock, so the audio rate never gates it.
   dpm_pointer u_pointer (
      .clk_sys(clk_sys),
      .rst(rst | dev_reset),
      .ptr_load(ptr_load),
      .ptr_value(ptr_value),
      .byte_done(byte_done),
      .ptr(ptr)
   );

   assign eff_cfg = state.cfg;
   assign osr = speed_osr(state.cfg.speed);
   assign deemph_scale_q8 = state.scale;
   assign powered_down = (state.st == dpm_pkg::DPM_ST_LOWPWR) ||
                         (state.st == dpm_pkg::DPM_ST_WAIT);
   assign powering_up = (state.st == dpm_pkg::DPM_ST_POWERUP);

   // Mute covers every state in which audio could click.
   assign mute_control = dev_reset || (state.st != dpm_pkg::DPM_ST_RUN) ||
                         (state.soft_mode && soft_cfg.mute_bits) || !ratio_valid;
endmodule // dpm_control

// ===== rtl/dpm_pointer.sv
`timescale 1ns/1ns
// Control port register pointer with optional auto-increment.
module dpm_pointer (
   input wire logic clk_sys, // System clock.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic ptr_load, // Pulse: load a new pointer byte.
   input wire logic [7:0] ptr_value, // Pointer byte to load.
   input wire logic byte_done, // Pulse: one data byte transferred.
   output logic [7:0] ptr // Current pointer.
);
   typedef struct packed {
      logic [7:0] ptr;
   } dpm_ptr_state_t;

   dpm_ptr_state_t state;
   dpm_ptr_state_t next_state;

   // A load wins over an increment, since it names the next register.
   always_comb begin
      next_state = state;
      if (ptr_load) begin
         next_state.ptr = ptr_value;
      end else if (byte_done && state.ptr[dpm_pkg::DPM_PTR_FLAG_BIT]) begin
         // Wraps within five bits and leaves the flag alone.
         next_state.ptr[dpm_pkg::DPM_PTR_ADDR_W-1:0] =
            state.ptr[dpm_pkg::DPM_PTR_ADDR_W-1:0] + 5'h01;
      end
      // Flag clear: pointer holds across successive bytes.
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state.ptr <= dpm_pkg::DPM_PTR_RESET;
      end else begin
         state <= next_state;
      end
   end

   assign ptr = state.ptr;
endmodule // dpm_pointer
